// File: supervisor_pkg.sv
package supervisor_pkg;
   // clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_NS = 20;
   localparam int RST_SHORT_US = 750;
   localparam int RST_LONG_MS = 200;
   localparam int WD_INT_MS = 1600;
   localparam int FILT_NS = 1000;
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int FILT_W = 8;
   localparam logic [31:0] RST_SHORT_CYC = 32'(RST_SHORT_US * (CLK_HZ / 1_000_000));
   localparam logic [31:0] RST_LONG_CYC = 32'(RST_LONG_MS * (CLK_HZ / 1000));
   // watchdog windows in watchdog clock ticks, internal tick length in clock cycles
   localparam logic [15:0] WD_INT_LEN = 16'h2001;
   localparam logic [15:0] WD_EXT_LEN = 16'h0081;
   localparam logic [15:0] WD_INT_LOW = 16'(WD_INT_LEN / 16'h0020);
   localparam logic [15:0] WD_EXT_LOW = 16'h0005;
   localparam logic [31:0] WD_INT_TICK_CYC = 32'((WD_INT_MS * (CLK_HZ / 1000)) / int'(WD_INT_LEN));
   // timing select pin codes
   localparam logic [1:0] TSEL_OPEN = 2'h0;
   localparam logic [1:0] TSEL_PUMP = 2'h1;
   localparam logic [1:0] WSEL_GND = 2'h0;
   localparam logic [1:0] WSEL_BIAS = 2'h1;
   // synchroniser reset levels: kick idles high, every other pin low
   localparam logic [9:0] SYNC_IDLE = 10'h008;
   // apb map
   localparam int AW = 12;
   localparam logic [AW-1:0] ADDR_TMO_CAP = 12'h000;
   localparam logic [AW-1:0] ADDR_WD_CAP = 12'h004;
   localparam logic [AW-1:0] ADDR_STATUS = 12'h008;
   localparam logic [AW-1:0] ADDR_WD_COUNT = 12'h00c;
   localparam logic [31:0] TMO_CAP_RST = 32'h0000_c350;
   localparam logic [31:0] WD_CAP_RST = 32'h0000_2710;
   // status fields
   localparam int ST_RST_BIT = 0;
   localparam int ST_UVLO_BIT = 1;
   localparam int ST_SENSE_BIT = 2;
   localparam int ST_PUMP_BIT = 3;
   localparam int ST_EARLY_BIT = 4;
   localparam int ST_MISS_BIT = 5;
   localparam int ST_WDON_BIT = 6;
   typedef enum logic [1:0] {SV_HOLD, SV_TIMEOUT, SV_RUN} sv_state_t;
endpackage : supervisor_pkg

// File: reset_supervisor.sv
// How it works
// - reset pulled low while sense is below threshold or pump is out of regulation
// - reset held one full timeout after sense and pump both become good
// - at timeout end the pull-down turns off, pin left floating
// - timeout is short when open, long when tied to pump, else programmed
// - sense and pump flags must stay stable before they are believed
// - lockout holds reset, ignores sense and pump, timeout waits for its end
// - early kick or missing kick forces reset for one timeout
// - after a watchdog reset the watchdog count restarts at zero
// - watchdog count stays clear while reset is asserted, runs after release
// - upper bound lies one watchdog tick before the end of reset time
// - internal watchdog reset time spans 8193 ticks
// - internal lower bound is reset time divided by 32
// - external reset time spans 129 ticks, upper bound at 128
// - external lower bound is five ticks into the count
// - watchdog select picks programmed period, internal period, or disables it
// - both power-good pins low when both enables low or in lockout
// - else each power-good low outside its window, floating inside it
//
// Decided for this implementation: the register offsets and the APB slave port.
module reset_supervisor
   import supervisor_pkg::*;
#(
   parameter logic [31:0] RST_SHORT = supervisor_pkg::RST_SHORT_CYC,
   parameter logic [31:0] RST_LONG = supervisor_pkg::RST_LONG_CYC,
   parameter logic [31:0] WD_INT_TICK = supervisor_pkg::WD_INT_TICK_CYC
)
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [supervisor_pkg::AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // monitored flags and pins
   input wire logic RESET_SENSE_INPUT,
   input wire logic PUMP_IN_REG,
   input wire logic UVLO,
   input wire logic WATCHDOG_KICK,
   input wire logic LOW_RAIL_ENABLE,
   input wire logic HIGH_RAIL_ENABLE,
   input wire logic LOW_RAIL_OV,
   input wire logic LOW_RAIL_UV,
   input wire logic HIGH_RAIL_OV,
   input wire logic HIGH_RAIL_UV,
   input wire logic [1:0] RESET_TIMING_SELECT,
   input wire logic [1:0] WATCHDOG_TIMING_SELECT,
   // open-drain outputs
   output logic SUP_RESET_N_O,
   output logic SUP_RESET_N_OE,
   output logic LOW_RAIL_POWER_GOOD_O,
   output logic LOW_RAIL_POWER_GOOD_OE,
   output logic HIGH_RAIL_POWER_GOOD_O,
   output logic HIGH_RAIL_POWER_GOOD_OE
);
   import supervisor_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [9:0] raw_in;
   logic [9:0] sync1_ff;
   logic [9:0] sync2_ff;
   assign raw_in = {HIGH_RAIL_UV, HIGH_RAIL_OV, LOW_RAIL_UV, LOW_RAIL_OV, HIGH_RAIL_ENABLE,
                    LOW_RAIL_ENABLE, WATCHDOG_KICK, UVLO, PUMP_IN_REG, RESET_SENSE_INPUT};
   genvar gi;
   generate
      for (gi = 0; gi < 10; gi++)
      begin : g_sync
         always_ff @(posedge MCLK)
         begin
            // idle levels in reset, so leaving reset shows no false kick edge
            sync1_ff[gi] <= RESET_N ? raw_in[gi] : SYNC_IDLE[gi];
            sync2_ff[gi] <= RESET_N ? sync1_ff[gi] : SYNC_IDLE[gi];
         end
      end
   endgenerate
   wire uvlo_s = sync2_ff[2];
   wire kick_s = sync2_ff[3];
   wire shut_s = !sync2_ff[4] && !sync2_ff[5];

   ////////////////////////////////////////////////////////////////////////////////
   // glitch filter on sense and pump
   logic [1:0] filt_ff;
   logic [FILT_W-1:0] fcnt_ff [2];
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_filt
         wire differ = sync2_ff[gi] != filt_ff[gi];
         wire done = fcnt_ff[gi] == FILT_W'(FILT_CYC - 1);
         always_ff @(posedge MCLK)
         begin
            if (!RESET_N)
            begin
               filt_ff[gi] <= 1'b0;
               fcnt_ff[gi] <= '0;
            end
            else
            begin
               fcnt_ff[gi] <= (differ && !done) ? fcnt_ff[gi] + 1'b1 : '0;
               if (differ && done)
                  filt_ff[gi] <= sync2_ff[gi];
            end
         end
      end
   endgenerate
   // lockout masks sense and pump entirely
   wire cond_ok = filt_ff[0] && filt_ff[1] && !uvlo_s;

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] tmo_cap_ff;
   logic [31:0] wd_cap_ff;
   logic early_ff;
   logic miss_ff;
   logic [31:0] prdata_ff;
   wire setup = PSEL && !PENABLE;
   wire access = PSEL && PENABLE;
   wire hit_tmo = PADDR == ADDR_TMO_CAP;
   wire hit_wd = PADDR == ADDR_WD_CAP;
   wire hit_st = PADDR == ADDR_STATUS;
   wire hit_cnt = PADDR == ADDR_WD_COUNT;
   wire mapped = hit_tmo || hit_wd || hit_st || hit_cnt;
   wire wr = access && PWRITE;

   ////////////////////////////////////////////////////////////////////////////////
   // supervisor state
   sv_state_t state_ff;
   sv_state_t nxt_state;
   logic [31:0] tmo_cnt_ff;
   logic rst_pull_ff;
   logic [15:0] wd_cnt_ff;
   logic [31:0] div_ff;
   // capacitor count of zero would never expire, so it is clamped
   wire [31:0] tmo_cap_len = (tmo_cap_ff == 32'h0) ? 32'h1 : tmo_cap_ff;
   wire [31:0] tmo_len = (RESET_TIMING_SELECT == TSEL_OPEN) ? RST_SHORT :
                         (RESET_TIMING_SELECT == TSEL_PUMP) ? RST_LONG : tmo_cap_len;
   wire tmo_done = tmo_cnt_ff >= tmo_len - 32'h1;
   wire wd_on = WATCHDOG_TIMING_SELECT != WSEL_GND;
   wire wd_int = WATCHDOG_TIMING_SELECT == WSEL_BIAS;
   wire [31:0] wd_cap_len = (wd_cap_ff == 32'h0) ? 32'h1 : wd_cap_ff;
   wire [31:0] tick_len = wd_int ? WD_INT_TICK : wd_cap_len;
   wire [15:0] wd_len = wd_int ? WD_INT_LEN : WD_EXT_LEN;
   wire [15:0] wd_low = wd_int ? WD_INT_LOW : WD_EXT_LOW;
   wire [15:0] wd_upper = wd_len - 16'h1;
   wire tick = div_ff >= tick_len - 32'h1;
   logic kick_d_ff;
   // falling edge of the kick, as the controller is expected to space them
   wire kick_fall = kick_d_ff && !kick_s;
   wire running = state_ff == SV_RUN && wd_on;
   wire wd_early = running && kick_fall && wd_cnt_ff < wd_low;
   wire wd_miss = running && !kick_fall && wd_cnt_ff >= wd_upper;
   wire wd_fault = wd_early || wd_miss;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         SV_HOLD:
            if (cond_ok)
               nxt_state = SV_TIMEOUT;
         SV_TIMEOUT:
            if (!cond_ok)
               nxt_state = SV_HOLD;
            else if (tmo_done)
               nxt_state = SV_RUN;
         SV_RUN:
            if (!cond_ok)
               nxt_state = SV_HOLD;
            else if (wd_fault)
               nxt_state = SV_TIMEOUT;
         default:
            nxt_state = SV_HOLD;
      endcase
   end

   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         state_ff <= SV_HOLD;
         tmo_cnt_ff <= '0;
         rst_pull_ff <= 1'b1;
         kick_d_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         tmo_cnt_ff <= (nxt_state == SV_TIMEOUT && state_ff == SV_TIMEOUT) ? tmo_cnt_ff + 32'h1 : '0;
         rst_pull_ff <= nxt_state != SV_RUN;
         kick_d_ff <= kick_s;
      end
   end

   // watchdog clock divider and window counter, cleared outside run
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N || !running || wd_fault || kick_fall)
      begin
         wd_cnt_ff <= '0;
         div_ff <= '0;
      end
      else
      begin
         div_ff <= tick ? '0 : div_ff + 32'h1;
         if (tick)
            wd_cnt_ff <= wd_cnt_ff + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave
   wire [31:0] status = {25'h0, wd_on, miss_ff, early_ff, filt_ff[1], filt_ff[0], uvlo_s, rst_pull_ff};
   wire [31:0] rd_mux = hit_tmo ? tmo_cap_ff : hit_wd ? wd_cap_ff : hit_st ? status :
                        hit_cnt ? {16'h0, wd_cnt_ff} : 32'h0;
   always_ff @(posedge MCLK)
   begin
      if (!RESET_N)
      begin
         tmo_cap_ff <= TMO_CAP_RST;
         wd_cap_ff <= WD_CAP_RST;
         early_ff <= 1'b0;
         miss_ff <= 1'b0;
         prdata_ff <= '0;
      end
      else
      begin
         if (wr && hit_tmo)
            tmo_cap_ff <= PWDATA;
         if (wr && hit_wd)
            wd_cap_ff <= PWDATA;
         // hardware set wins over a write-one clear in the same cycle
         early_ff <= wd_early || (early_ff && !(wr && hit_st && PWDATA[ST_EARLY_BIT]));
         miss_ff <= wd_miss || (miss_ff && !(wr && hit_st && PWDATA[ST_MISS_BIT]));
         if (setup && !PWRITE)
            prdata_ff <= rd_mux;
      end
   end
   assign PRDATA = prdata_ff;
   assign PREADY = 1'b1;
   assign PSLVERR = access && !mapped;

   ////////////////////////////////////////////////////////////////////////////////
   // open-drain pins
   wire pg_force = shut_s || uvlo_s;
   assign SUP_RESET_N_O = 1'b0;
   assign SUP_RESET_N_OE = rst_pull_ff;
   assign LOW_RAIL_POWER_GOOD_O = 1'b0;
   assign LOW_RAIL_POWER_GOOD_OE = pg_force || sync2_ff[6] || sync2_ff[7];
   assign HIGH_RAIL_POWER_GOOD_O = 1'b0;
   assign HIGH_RAIL_POWER_GOOD_OE = pg_force || sync2_ff[8] || sync2_ff[9];

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   sequence s_wd_fault_seen;
      wd_fault && cond_ok;
   endsequence
   sequence s_timeout_restart;
      state_ff == SV_TIMEOUT && tmo_cnt_ff == 32'h0 && SUP_RESET_N_OE;
   endsequence

   property p_bad_cond_pulls;
      !cond_ok |=> SUP_RESET_N_OE && state_ff == SV_HOLD;
   endproperty
   a_bad_cond_pulls: assert property (p_bad_cond_pulls) else $error("reset not pulled on bad condition");

   property p_full_timeout;
      $fell(SUP_RESET_N_OE) |-> $past(state_ff) == SV_TIMEOUT && $past(tmo_cnt_ff) == tmo_len - 32'h1;
   endproperty
   a_full_timeout: assert property (p_full_timeout) else $error("reset released before full timeout");

   property p_release_floats;
      state_ff == SV_RUN |-> !SUP_RESET_N_OE && !SUP_RESET_N_O;
   endproperty
   a_release_floats: assert property (p_release_floats) else $error("reset pin driven while released");

   property p_lockout_holds;
      uvlo_s |=> SUP_RESET_N_OE && state_ff == SV_HOLD && tmo_cnt_ff == 32'h0;
   endproperty
   a_lockout_holds: assert property (p_lockout_holds) else $error("lockout did not hold reset");

   property p_filter_stable;
      $changed(filt_ff[0]) |-> $past(fcnt_ff[0]) == FILT_W'(FILT_CYC - 1);
   endproperty
   a_filter_stable: assert property (p_filter_stable) else $error("sense flag passed unfiltered");

   property p_wd_fault_resets;
      s_wd_fault_seen |=> s_timeout_restart;
   endproperty
   a_wd_fault_resets: assert property (p_wd_fault_resets) else $error("watchdog fault did not reset");

   property p_wd_clear_in_reset;
      state_ff != SV_RUN |=> wd_cnt_ff == 16'h0 && div_ff == 32'h0;
   endproperty
   a_wd_clear_in_reset: assert property (p_wd_clear_in_reset) else $error("watchdog ran during reset");

   property p_wd_restart;
      state_ff == SV_TIMEOUT ##1 state_ff == SV_RUN |-> wd_cnt_ff == 16'h0;
   endproperty
   a_wd_restart: assert property (p_wd_restart) else $error("watchdog not restarted from zero");

   property p_upper_bound;
      wd_miss |-> wd_cnt_ff == wd_len - 16'h1 && $past(wd_cnt_ff) != wd_cnt_ff;
   endproperty
   a_upper_bound: assert property (p_upper_bound) else $error("missing kick at wrong count");

   property p_pg_forced;
      pg_force |-> LOW_RAIL_POWER_GOOD_OE && HIGH_RAIL_POWER_GOOD_OE;
   endproperty
   a_pg_forced: assert property (p_pg_forced) else $error("power good not forced low");

   property p_pg_window;
      !pg_force && !sync2_ff[8] && !sync2_ff[9] |-> !HIGH_RAIL_POWER_GOOD_OE;
   endproperty
   a_pg_window: assert property (p_pg_window) else $error("power good low inside window");
endmodule : reset_supervisor

// File: kick_partner.sv
module kick_partner
(
   // clock
   input wire logic clk,
   // command from the bench
   input wire logic run,
   input wire logic signed [31:0] gap,
   // kick pin
   output logic kick
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   initial kick = 1'b1;
   ////////////////////////////////////////
   // one falling edge every gap cycles, only while told to run
   // idle high so that stopping never makes a stray falling edge
   always @(posedge clk)
   begin
      if (!run)
      begin
         cnt <= 0;
         kick <= 1'b1;
      end
      else if (cnt >= gap - 1)
      begin
         cnt <= 0;
         kick <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 1;
         if (cnt == gap / 2)
            kick <= 1'b1;
      end
   end
endmodule : kick_partner

// File: reset_supervisor_windowed_watchdog_test.sv
module reset_supervisor_windowed_watchdog_test;
   timeunit 1ns;
   timeprecision 1ps;
   import supervisor_pkg::*;
   logic MCLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, UVLO, WATCHDOG_KICK, err, run;
   logic RESET_SENSE_INPUT, PUMP_IN_REG, LOW_RAIL_ENABLE, HIGH_RAIL_ENABLE;
   logic LOW_RAIL_OV, LOW_RAIL_UV, HIGH_RAIL_OV, HIGH_RAIL_UV, SUP_RESET_N_O, SUP_RESET_N_OE;
   logic LOW_RAIL_POWER_GOOD_O, LOW_RAIL_POWER_GOOD_OE, HIGH_RAIL_POWER_GOOD_O, HIGH_RAIL_POWER_GOOD_OE;
   logic [1:0] RESET_TIMING_SELECT, WATCHDOG_TIMING_SELECT;
   logic [AW-1:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   int n_fail, checked, gap, cyc;
   // expected timeouts for open, pump-tied and programmed selects
   int tmo_q[$] = '{20, 40, 30};
   reset_supervisor #(.RST_SHORT(32'h14), .RST_LONG(32'h28), .WD_INT_TICK(32'h2)) i_dut (.MCLK, .RESET_N,
      .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RESET_SENSE_INPUT,
      .PUMP_IN_REG, .UVLO, .WATCHDOG_KICK, .LOW_RAIL_ENABLE, .HIGH_RAIL_ENABLE, .LOW_RAIL_OV,
      .LOW_RAIL_UV, .HIGH_RAIL_OV, .HIGH_RAIL_UV, .RESET_TIMING_SELECT, .WATCHDOG_TIMING_SELECT,
      .SUP_RESET_N_O, .SUP_RESET_N_OE, .LOW_RAIL_POWER_GOOD_O, .LOW_RAIL_POWER_GOOD_OE,
      .HIGH_RAIL_POWER_GOOD_O, .HIGH_RAIL_POWER_GOOD_OE);
   kick_partner i_kick (.clk(MCLK), .run(run), .gap(gap), .kick(WATCHDOG_KICK));
   ////////////////////////////////////////
   function automatic logic pg_exp(input logic bad);
      return UVLO | !(LOW_RAIL_ENABLE | HIGH_RAIL_ENABLE) | bad;
   endfunction : pg_exp
   task print_verdict;
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task chk_rng(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi)
      begin
         n_fail++;
         $display("MISMATCH %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_rng
   // bounded wait for the reset pull-down to reach v
   task wait_oe(input logic v, input int lim);
      cyc = 0;
      while (SUP_RESET_N_OE !== v)
      begin
         @(posedge MCLK);
         cyc++;
         if (cyc > lim)
         begin
            n_fail++;
            $display("MISMATCH %0t wait ran out", $time);
            print_verdict();
         end
      end
   endtask : wait_oe
   task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      int k;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      k = 0;
      do
      begin
         @(posedge MCLK);
         k++;
      end
      while (PREADY !== 1'b1 && k < 50);
      chk(PREADY, 32'h1);
      if (PREADY !== 1'b1)
         print_verdict();
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   ////////////////////////////////////////
   initial
   begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end
   initial
   begin
      {RESET_N, PSEL, PENABLE, PWRITE, RESET_SENSE_INPUT, PUMP_IN_REG, run, PADDR, PWDATA} = '0;
      {LOW_RAIL_OV, LOW_RAIL_UV, HIGH_RAIL_OV, HIGH_RAIL_UV, RESET_TIMING_SELECT, WATCHDOG_TIMING_SELECT} = '0;
      {UVLO, LOW_RAIL_ENABLE, HIGH_RAIL_ENABLE} = 3'h7;
      {n_fail, checked, gap} = '0;
      void'($urandom(32'hba89));
      repeat (6) @(posedge MCLK);
      RESET_N <= 1'b1;
      apb(1'b0, ADDR_WD_CAP, 32'h0);
      chk(rd, WD_CAP_RST);
      apb(1'b1, 12'h010, 32'h5);
      chk(err, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      // lockout masks good sense and pump
      {RESET_SENSE_INPUT, PUMP_IN_REG} <= 2'b11;
      repeat (200) @(posedge MCLK);
      chk(SUP_RESET_N_OE, 32'h1);
      chk(LOW_RAIL_POWER_GOOD_OE, 32'h1);
      UVLO <= 1'b0;
      wait_oe(1'b0, 300);
      chk_rng(cyc, 20, FILT_CYC + 26);
      chk(SUP_RESET_N_O, 32'h0);
      ////////////////////////////////////////
      foreach (tmo_q[i])
      begin
         if (i == 2)
            apb(1'b1, ADDR_TMO_CAP, 32'h1e);
         RESET_TIMING_SELECT <= 2'(i);
         if (i == 1)
            PUMP_IN_REG <= 1'b0;
         else
            RESET_SENSE_INPUT <= 1'b0;
         wait_oe(1'b1, 200);
         chk_rng(cyc, FILT_CYC, FILT_CYC + 5);
         {RESET_SENSE_INPUT, PUMP_IN_REG} <= 2'b11;
         wait_oe(1'b0, 300);
         chk_rng(cyc, FILT_CYC + tmo_q[i], FILT_CYC + tmo_q[i] + 5);
      end
      RESET_SENSE_INPUT <= 1'b0;
      repeat (10) @(posedge MCLK);
      RESET_SENSE_INPUT <= 1'b1;
      repeat (100) @(posedge MCLK);
      chk(SUP_RESET_N_OE, 32'h0);
      ////////////////////////////////////////
      // watchdog in programmed mode, two clocks per tick
      apb(1'b1, ADDR_WD_CAP, 32'h2);
      RESET_TIMING_SELECT <= TSEL_OPEN;
      WATCHDOG_TIMING_SELECT <= 2'h2;
      gap <= 40;
      run <= 1'b1;
      repeat (800) @(posedge MCLK);
      chk(SUP_RESET_N_OE, 32'h0);
      gap <= 6;
      wait_oe(1'b1, 100);
      run <= 1'b0;
      wait_oe(1'b0, 100);
      chk_rng(cyc, 19, 24);
      wait_oe(1'b1, 400);
      chk_rng(cyc, 252, 262);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[5:4], 32'h3);
      chk(rd[6:0], 32'h7d);
      wait_oe(1'b0, 100);
      apb(1'b0, ADDR_WD_COUNT, 32'h0);
      chk(rd[15:2], 32'h0);
      // internal mode
      WATCHDOG_TIMING_SELECT <= WSEL_BIAS;
      gap <= 1000;
      run <= 1'b1;
      repeat (5000) @(posedge MCLK);
      chk(SUP_RESET_N_OE, 32'h0);
      gap <= 400;
      wait_oe(1'b1, 2000);
      run <= 1'b0;
      wait_oe(1'b0, 100);
      wait_oe(1'b1, 17000);
      chk_rng(cyc, 16380, 16392);
      wait_oe(1'b0, 100);
      WATCHDOG_TIMING_SELECT <= WSEL_GND;
      repeat (17000) @(posedge MCLK);
      chk(SUP_RESET_N_OE, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[ST_WDON_BIT], 32'h0);
      // sticky kick flags clear on a write of ones while the watchdog is off
      apb(1'b1, ADDR_STATUS, 32'h30);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[5:4], 32'h0);
      ////////////////////////////////////////
      for (int k = 0; k < 64; k++)
      begin
         {UVLO, LOW_RAIL_ENABLE, HIGH_RAIL_ENABLE, LOW_RAIL_OV, LOW_RAIL_UV, HIGH_RAIL_OV,
            HIGH_RAIL_UV} <= 7'($urandom);
         repeat (4) @(posedge MCLK);
         chk(LOW_RAIL_POWER_GOOD_OE, pg_exp(LOW_RAIL_OV | LOW_RAIL_UV));
         chk(HIGH_RAIL_POWER_GOOD_OE, pg_exp(HIGH_RAIL_OV | HIGH_RAIL_UV));
      end
      chk(HIGH_RAIL_POWER_GOOD_O, 32'h0);
      chk(LOW_RAIL_POWER_GOOD_O, 32'h0);
      print_verdict();
   end
endmodule : reset_supervisor_windowed_watchdog_test
